// ==== src/rfs_supervisor.sv ====
// regulator fault supervisor: debounce, protection, flags and register port
`timescale 1ns/100ps
`default_nettype none
module rfs_supervisor
  import rfs_pkg::*;
(
  input wire logic clk,
  input wire logic chip_reset_pin_n,
  input wire rfs_bus_req_t bus_req,
  output logic [7:0] rdata,
  input wire rfs_cmp_t cmp_in,
  output rfs_drive_t drive,
  output logic irq_out_n
);

  function automatic logic [CNT_W-1:0] deb_limit(input int lane, input logic rising);
    logic [CNT_W-1:0] lim;
    lim = CNT_W'(DEB_TICKS);
    if (lane >= D_FB && lane < D_FB + NUM_REG && rising)
    begin
      lim = CNT_W'(OVL_TICKS);
    end
    return lim;
  endfunction

  function automatic logic hit(input rfs_bus_req_t r, input logic [3:0] a);
    return r.addr == a;
  endfunction

  // sample tick
  logic [TICK_W-1:0] div_q;
  logic tick_q;
  always_ff @(posedge clk or negedge chip_reset_pin_n)
  begin
    if (!chip_reset_pin_n)
    begin
      div_q <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      tick_q <= (div_q == TICK_W'(TICK_CYC - 1));
      div_q <= (div_q == TICK_W'(TICK_CYC - 1)) ? '0 : div_q + 1'b1;
    end
  end

  // two-flop synchronisers for every comparator and enable pin
  logic [NSYNC-1:0] sync1_q, sync2_q;
  always_ff @(posedge clk or negedge chip_reset_pin_n)
  begin
    if (!chip_reset_pin_n)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= {cmp_in.enable_pin_one, cmp_in.supply_input, cmp_in.tsd, cmp_in.warn_hi,
                  cmp_in.warn_lo, cmp_in.ovp, cmp_in.fb_low, cmp_in.ilim};
      sync2_q <= sync1_q;
    end
  end

  logic [7:0] ctrl_q, disch_q, mask_q;
  logic [NDB-1:0] deb_in, filt_q;
  always_comb
  begin
    deb_in = sync2_q[NDB-1:0];
    deb_in[D_TWARN] = ctrl_q[F_WARN_SEL] ? sync2_q[S_WHI] : sync2_q[S_WLO];
    deb_in[D_TSD] = sync2_q[S_TSD];
    deb_in[D_SUP] = sync2_q[S_SUP];
  end

  // window accuracy is one tick, except a supply loss, which the filter takes at once
  genvar g;
  generate
    for (g = 0; g < NDB; g++)
    begin : g_deb
      logic [CNT_W-1:0] cnt_q;
      always_ff @(posedge clk or negedge chip_reset_pin_n)
      begin
        if (!chip_reset_pin_n)
        begin
          cnt_q <= '0;
          filt_q[g] <= 1'b0;
        end
        else if (g == D_SUP && !deb_in[g])
        begin
          cnt_q <= '0;
          filt_q[g] <= 1'b0;
        end
        else if (deb_in[g] == filt_q[g])
        begin
          cnt_q <= '0;
        end
        else if (tick_q)
        begin
          if (cnt_q + 1'b1 >= deb_limit(g, deb_in[g]))
          begin
            filt_q[g] <= deb_in[g];
            cnt_q <= '0;
          end
          else
          begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
      end
    end
  endgenerate

  logic ovp_live, tsd_live, warn_live, sup_ok;
  logic [NUM_REG-1:0] ilim_live, fb_low_filt;
  assign ovp_live = filt_q[D_OVP];
  assign tsd_live = filt_q[D_TSD];
  assign warn_live = filt_q[D_TWARN];
  assign sup_ok = filt_q[D_SUP];
  assign ilim_live = filt_q[D_ILIM +: NUM_REG];
  assign fb_low_filt = filt_q[D_FB +: NUM_REG];

  rfs_mode_t mode_q, mode_d;
  logic [NUM_REG-1:0] reg_on_q, reg_on_d, run_q, sc_evt;
  logic [NUM_REG-1:0] reg_current_limit_flag_q, reg_short_circuit_flag_q;
  logic temp_warning_flag_q, temp_shutdown_flag_q, supply_overvoltage_flag_q, reset_flag_q;
  logic in_shutdown;
  assign in_shutdown = (mode_q == MODE_SHUTDOWN);

  always_comb
  begin
    if (!sup_ok)
    begin
      mode_d = MODE_SHUTDOWN;
    end
    else if (|reg_on_q)
    begin
      mode_d = MODE_ACTIVE;
    end
    else
    begin
      mode_d = MODE_STANDBY;
    end
  end

  always_ff @(posedge clk or negedge chip_reset_pin_n)
  begin
    if (!chip_reset_pin_n)
    begin
      mode_q <= MODE_SHUTDOWN;
    end
    else
    begin
      mode_q <= mode_d;
    end
  end

  // regulator enable gating
  logic [NUM_REG-1:0] req;
  logic block_all;
  always_comb
  begin
    // pin-controlled enables use the bare synchronised level
    req = ctrl_q[NUM_REG-1:0] & {NUM_REG{!ctrl_q[F_PIN_CTRL] || sync2_q[S_EN]}};
    block_all = ovp_live || supply_overvoltage_flag_q || tsd_live || temp_shutdown_flag_q
                || !sup_ok || in_shutdown;
    reg_on_d = req & ~reg_short_circuit_flag_q & {NUM_REG{!block_all}};
  end

  always_ff @(posedge clk or negedge chip_reset_pin_n)
  begin
    if (!chip_reset_pin_n)
    begin
      reg_on_q <= '0;
    end
    else
    begin
      reg_on_q <= reg_on_d & ~sc_evt;
    end
  end

  // start-up check and running overload
  generate
    for (g = 0; g < NUM_REG; g++)
    begin : g_sc
      logic [CNT_W-1:0] chk_q;
      always_ff @(posedge clk or negedge chip_reset_pin_n)
      begin
        if (!chip_reset_pin_n)
        begin
          run_q[g] <= 1'b0;
          chk_q <= '0;
        end
        else if (!reg_on_q[g])
        begin
          run_q[g] <= 1'b0;
          chk_q <= '0;
        end
        else if (!run_q[g] && reg_on_d[g] && chk_q == '0 && !sc_evt[g] && $rose(reg_on_q[g]))
        begin
          run_q[g] <= 1'b1;
        end
        else if (run_q[g] && tick_q)
        begin
          chk_q <= chk_q + 1'b1;
          if (chk_q + 1'b1 >= CNT_W'(SC_TICKS))
          begin
            run_q[g] <= 1'b0;
          end
        end
      end
      assign sc_evt[g] = reg_on_q[g] && (
        (run_q[g] && tick_q && chk_q + 1'b1 >= CNT_W'(SC_TICKS) && sync2_q[S_FB + g])
        || (!run_q[g] && chk_q != '0 && fb_low_filt[g]));
    end
  endgenerate

  // register writes and clears
  logic wr_ctrl, wr_top, wr_reg;
  assign wr_ctrl = bus_req.wr && !in_shutdown;
  assign wr_top = wr_ctrl && hit(bus_req, A_INT_TOP);
  assign wr_reg = wr_ctrl && hit(bus_req, A_INT_REG);

  always_ff @(posedge clk or negedge chip_reset_pin_n)
  begin
    if (!chip_reset_pin_n)
    begin
      ctrl_q <= CTRL_RST;
      disch_q <= DISCH_RST;
      mask_q <= MASK_RST;
    end
    else if (in_shutdown)
    begin
      ctrl_q <= CTRL_RST;
      disch_q <= DISCH_RST;
      mask_q <= MASK_RST;
    end
    else if (wr_ctrl)
    begin
      if (hit(bus_req, A_CTRL))
        ctrl_q <= bus_req.wdata;
      if (hit(bus_req, A_DISCH))
        disch_q <= bus_req.wdata;
      if (hit(bus_req, A_MASK))
        mask_q <= bus_req.wdata;
    end
  end

  // set always wins over a same-cycle clear
  always_ff @(posedge clk or negedge chip_reset_pin_n)
  begin
    if (!chip_reset_pin_n)
    begin
      reg_current_limit_flag_q <= '0;
      reg_short_circuit_flag_q <= '0;
    end
    else if (in_shutdown)
    begin
      reg_current_limit_flag_q <= '0;
      reg_short_circuit_flag_q <= '0;
    end
    else
    begin
      reg_current_limit_flag_q <= (reg_on_q & ilim_live)
        | (reg_current_limit_flag_q & ~({NUM_REG{wr_reg}} & bus_req.wdata[NUM_REG-1:0]));
      reg_short_circuit_flag_q <= sc_evt
        | (reg_short_circuit_flag_q & ~({NUM_REG{wr_reg}} & bus_req.wdata[7:4]));
    end
  end

  always_ff @(posedge clk or negedge chip_reset_pin_n)
  begin
    if (!chip_reset_pin_n)
    begin
      temp_warning_flag_q <= 1'b0;
      temp_shutdown_flag_q <= 1'b0;
      supply_overvoltage_flag_q <= 1'b0;
      reset_flag_q <= 1'b0;
    end
    else if (in_shutdown)
    begin
      temp_warning_flag_q <= 1'b0;
      temp_shutdown_flag_q <= 1'b0;
      supply_overvoltage_flag_q <= 1'b0;
      reset_flag_q <= sup_ok;
    end
    else
    begin
      temp_warning_flag_q <= warn_live
        || (temp_warning_flag_q && !(wr_top && bus_req.wdata[F_TWARN]));
      temp_shutdown_flag_q <= tsd_live
        || (temp_shutdown_flag_q && !(wr_top && bus_req.wdata[F_TSD]));
      supply_overvoltage_flag_q <= ovp_live
        || (supply_overvoltage_flag_q && !(wr_top && bus_req.wdata[F_OVP]));
      reset_flag_q <= reset_flag_q && !(wr_top && bus_req.wdata[F_RESET]);
    end
  end

  // summary bits follow the per-regulator flags
  logic [NUM_REG-1:0] summary;
  logic pending;
  assign summary = reg_current_limit_flag_q | reg_short_circuit_flag_q;
  assign pending = (|reg_current_limit_flag_q && !mask_q[M_ILIM])
    || (|reg_short_circuit_flag_q && !mask_q[M_SC])
    || (temp_warning_flag_q && !mask_q[M_TWARN])
    || (temp_shutdown_flag_q && !mask_q[M_TSD])
    || (supply_overvoltage_flag_q && !mask_q[M_OVP])
    || (reset_flag_q && !mask_q[M_RESET]);

  always_ff @(posedge clk or negedge chip_reset_pin_n)
  begin
    if (!chip_reset_pin_n)
    begin
      irq_out_n <= 1'b1;
    end
    else
    begin
      irq_out_n <= !pending;
    end
  end

  // power stage and discharge drive
  always_ff @(posedge clk or negedge chip_reset_pin_n)
  begin
    if (!chip_reset_pin_n)
    begin
      drive <= '0;
    end
    else
    begin
      drive.power_stage_en <= reg_on_q;
      drive.discharge_en <= ~reg_on_q & disch_q[NUM_REG-1:0];
      drive.gpio_force_low <= ovp_live && !in_shutdown;
    end
  end

  // read port, data valid the cycle after the strobe
  always_ff @(posedge clk or negedge chip_reset_pin_n)
  begin
    if (!chip_reset_pin_n)
    begin
      rdata <= '0;
    end
    else if (bus_req.rd)
    begin
      case (bus_req.addr)
        A_CTRL: rdata <= ctrl_q;
        A_DISCH: rdata <= disch_q;
        A_INT_TOP: rdata <= {reset_flag_q, supply_overvoltage_flag_q, temp_shutdown_flag_q,
                             temp_warning_flag_q, summary};
        A_INT_REG: rdata <= {reg_short_circuit_flag_q, reg_current_limit_flag_q};
        A_REG_STAT: rdata <= {reg_on_q, reg_on_q & ilim_live};
        A_TOP_STAT: rdata <= {2'b00, mode_q, ovp_live, tsd_live, warn_live};
        A_MASK: rdata <= mask_q;
        default: rdata <= '0;
      endcase
    end
    else
    begin
      rdata <= '0;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!chip_reset_pin_n);

  chk_irq_follows: assert property (pending |-> ##1 !irq_out_n ##0 $past(pending))
    else $error("irq not low while flag pending");
  chk_irq_release: assert property (!pending |=> irq_out_n)
    else $error("irq held with nothing pending");
  chk_sc_disables: assert property (sc_evt[0] |=> !reg_on_q[0] && reg_short_circuit_flag_q[0]
                                    && summary[0])
    else $error("short circuit did not disable and flag");
  chk_ovp_blocks: assert property (supply_overvoltage_flag_q |=> reg_on_q == '0)
    else $error("regulator on during overvoltage");
  chk_ovp_sticky: assert property (ovp_live && supply_overvoltage_flag_q && wr_top
                                   |=> supply_overvoltage_flag_q)
    else $error("overvoltage flag cleared while live");
  chk_tsd_blocks: assert property (temp_shutdown_flag_q |=> reg_on_q == '0)
    else $error("regulator on during thermal shutdown");
  chk_disch_gate: assert property ($fell(reg_on_q[0]) && disch_q[0] |=> drive.discharge_en[0]
                                   && !drive.power_stage_en[0])
    else $error("discharge not applied on disable");
  chk_uvlo_fast: assert property (!sync2_q[S_SUP] |-> ##2 mode_q == MODE_SHUTDOWN)
    else $error("supply loss not immediate");
  chk_reset_flag: assert property (in_shutdown && mode_d == MODE_STANDBY |=> reset_flag_q)
    else $error("reset flag not set leaving shutdown");
  chk_ilim_flag: assert property (reg_on_q[0] && ilim_live[0] && !in_shutdown
                                  |=> reg_current_limit_flag_q[0])
    else $error("current limit flag missed");

endmodule
`default_nettype wire

// ==== src/rfs_pkg.sv ====
// constants and carrier types for the regulator fault supervisor
package rfs_pkg;
  localparam int NUM_REG = 4;
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYC = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEB_TIME_US = 20;
  localparam int OVL_TIME_MS = 1;
  localparam int SC_CHECK_MS = 1;
  localparam int DEB_TICKS = (DEB_TIME_US * 1000 + TICK_NS - 1) / TICK_NS;
  localparam int OVL_TICKS = (OVL_TIME_MS * 1000000 + TICK_NS - 1) / TICK_NS;
  localparam int SC_TICKS = (SC_CHECK_MS * 1000000 + TICK_NS - 1) / TICK_NS;
  localparam int CNT_W = 10;
  localparam int TICK_W = 5;
  // synchroniser lanes
  localparam int S_ILIM = 0;
  localparam int S_FB = 4;
  localparam int S_OVP = 8;
  localparam int S_WLO = 9;
  localparam int S_WHI = 10;
  localparam int S_TSD = 11;
  localparam int S_SUP = 12;
  localparam int S_EN = 13;
  localparam int NSYNC = 14;
  // debounce lanes
  localparam int D_ILIM = 0;
  localparam int D_FB = 4;
  localparam int D_OVP = 8;
  localparam int D_TWARN = 9;
  localparam int D_TSD = 10;
  localparam int D_SUP = 11;
  localparam int NDB = 12;
  // register offsets
  localparam logic [3:0] A_CTRL = 4'h0;
  localparam logic [3:0] A_DISCH = 4'h1;
  localparam logic [3:0] A_INT_TOP = 4'h2;
  localparam logic [3:0] A_INT_REG = 4'h3;
  localparam logic [3:0] A_REG_STAT = 4'h4;
  localparam logic [3:0] A_TOP_STAT = 4'h5;
  localparam logic [3:0] A_MASK = 4'h6;
  // field positions
  localparam int F_PIN_CTRL = 4;
  localparam int F_WARN_SEL = 5;
  localparam int F_TWARN = 4;
  localparam int F_TSD = 5;
  localparam int F_OVP = 6;
  localparam int F_RESET = 7;
  localparam int M_ILIM = 0;
  localparam int M_SC = 1;
  localparam int M_TWARN = 2;
  localparam int M_TSD = 3;
  localparam int M_OVP = 4;
  localparam int M_RESET = 5;
  // values after reset
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DISCH_RST = 8'h0f;
  localparam logic [7:0] MASK_RST = 8'h00;

  typedef enum logic [2:0] {
    MODE_SHUTDOWN = 3'b001,
    MODE_STANDBY = 3'b010,
    MODE_ACTIVE = 3'b100
  } rfs_mode_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rfs_bus_req_t;

  typedef struct packed {
    logic [NUM_REG-1:0] ilim;
    logic [NUM_REG-1:0] fb_low;
    logic ovp;
    logic warn_lo;
    logic warn_hi;
    logic tsd;
    logic supply_input;
    logic enable_pin_one;
  } rfs_cmp_t;

  typedef struct packed {
    logic [NUM_REG-1:0] power_stage_en;
    logic [NUM_REG-1:0] discharge_en;
    logic gpio_force_low;
  } rfs_drive_t;
endpackage

// ==== dv/rfs_host_model.sv ====
// host-side model: register port master that reads and clears flags
`timescale 1ns/100ps
`default_nettype none
module rfs_host_model
  import rfs_pkg::*;
(
  input wire logic clk,
  output var rfs_bus_req_t bus_req,
  input wire logic [7:0] rdata
);
  // strobes idle low so nothing is taken before the first call
  initial bus_req = '0;

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask

  // data stands only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1;
    d = rdata;
    // back onto the edge so callers drive stimulus on it
    @(posedge clk);
  endtask

  // flags go away by writing ones to them, or when the supervisor enters shutdown
  task automatic clear(input logic [3:0] a, input logic [7:0] bits);
    wr(a, bits);
  endtask
endmodule
`default_nettype wire

// ==== dv/rfs_supervisor_tb.sv ====
// self-checking bench for the regulator fault supervisor
`timescale 1ns/100ps
`default_nettype none
module rfs_supervisor_tb
  import rfs_pkg::*;
;
  logic clk = 1'b0;
  logic chip_reset_pin_n = 1'b0;
  rfs_cmp_t cmp;
  rfs_bus_req_t bus_req;
  rfs_drive_t drive;
  logic [7:0] rdata;
  logic [7:0] d;
  logic irq_out_n;
  int err_count = 0;
  int comparisons = 0;

  always #20 clk = ~clk;

  rfs_supervisor dut_u (.clk(clk), .chip_reset_pin_n(chip_reset_pin_n), .bus_req(bus_req), .rdata(rdata),
    .cmp_in(cmp), .drive(drive), .irq_out_n(irq_out_n));
  rfs_host_model host_u (.clk(clk), .bus_req(bus_req), .rdata(rdata));

  task automatic final_report();
    $display("err_count %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_rd(input logic [3:0] a, input logic [7:0] exp);
    host_u.rd(a, d);
    chk(d, exp);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
  endtask

  // debounce is 20 ticks of 25 cycles plus sync, so 560 cycles is safely past it
  task automatic wait_irq_low(input int n);
    int i;
    for (i = 0; i < n && irq_out_n !== 1'b0; i++)
      @(posedge clk);
    if (irq_out_n !== 1'b0)
    begin
      err_count++;
      $display("[ERR] %0t interrupt never asserted", $time);
      final_report();
    end
  endtask

  task automatic wait_off(input int r);
    int i;
    for (i = 0; i < 26000 && drive.power_stage_en[r] !== 1'b0; i++)
      @(posedge clk);
    if (drive.power_stage_en[r] !== 1'b0)
    begin
      err_count++;
      $display("[ERR] %0t regulator never switched off", $time);
      final_report();
    end
    settle(2);
  endtask

  task automatic sc_power_up();
    chk_rd(A_TOP_STAT, 8'h08);
    wait_irq_low(700);
    chk_rd(A_INT_TOP, 8'h80);
    chk_rd(A_CTRL, CTRL_RST);
    chk_rd(A_DISCH, DISCH_RST);
    chk_rd(A_MASK, MASK_RST);
    chk_rd(A_TOP_STAT, 8'h10);
    chk_rd(4'hf, 8'h00);
    host_u.clear(A_INT_TOP, 8'h80);
    settle(3);
    chk({7'h0, irq_out_n}, 8'h01);
  endtask

  task automatic sc_limit_and_short();
    cmp.fb_low[1] <= 1'b1;
    host_u.wr(A_DISCH, 8'h0e);
    host_u.wr(A_CTRL, 8'h03);
    settle(4);
    chk({4'h0, drive.power_stage_en}, 8'h03);
    cmp.ilim[0] <= 1'b1;
    settle(560);
    chk({7'h0, irq_out_n}, 8'h00);
    chk_rd(A_INT_REG, 8'h01);
    chk_rd(A_REG_STAT, 8'h31);
    cmp.ilim[0] <= 1'b0;
    settle(560);
    host_u.clear(A_INT_REG, 8'h01);
    chk_rd(A_INT_REG, 8'h00);
    chk_rd(A_REG_STAT, 8'h30);
    // start-up check runs 1000 ticks after turn-on
    wait_off(1);
    // regulators 2 and 3 sit off with their discharge bits set
    chk({drive.power_stage_en, drive.discharge_en}, 8'h1e);
    chk_rd(A_INT_REG, 8'h20);
    chk_rd(A_INT_TOP, 8'h02);
    chk_rd(A_REG_STAT, 8'h10);
    chk({7'h0, irq_out_n}, 8'h00);
    cmp.fb_low[1] <= 1'b0;
    host_u.clear(A_INT_REG, 8'h20);
    settle(4);
    chk({4'h0, drive.power_stage_en}, 8'h03);
  endtask

  task automatic sc_warning();
    cmp.warn_lo <= 1'b1;
    settle(560);
    chk_rd(A_INT_TOP, 8'h10);
    chk_rd(A_TOP_STAT, 8'h21);
    cmp.warn_lo <= 1'b0;
    settle(560);
    host_u.clear(A_INT_TOP, 8'h10);
    chk_rd(A_INT_TOP, 8'h00);
  endtask

  task automatic sc_overload();
    cmp.fb_low[0] <= 1'b1;
    wait_off(0);
    // discharge bit of regulator 0 was cleared, so no pulldown here
    chk({drive.power_stage_en, drive.discharge_en}, 8'h2c);
    chk_rd(A_INT_REG, 8'h10);
    chk_rd(A_INT_TOP, 8'h01);
    cmp.fb_low[0] <= 1'b0;
    host_u.clear(A_INT_REG, 8'h10);
    settle(4);
    chk({4'h0, drive.power_stage_en}, 8'h03);
  endtask

  task automatic sc_overvoltage();
    cmp.ovp <= 1'b1;
    settle(560);
    chk({3'h0, drive.gpio_force_low, drive.power_stage_en}, 8'h10);
    chk_rd(A_REG_STAT, 8'h00);
    host_u.clear(A_INT_TOP, 8'h40);
    chk_rd(A_INT_TOP, 8'h40);
    chk_rd(A_TOP_STAT, 8'h14);
    host_u.wr(A_CTRL, 8'h01);
    settle(4);
    chk({4'h0, drive.power_stage_en}, 8'h00);
    cmp.ovp <= 1'b0;
    settle(560);
    chk({4'h0, drive.power_stage_en}, 8'h00);
    host_u.clear(A_INT_TOP, 8'h40);
    chk_rd(A_INT_TOP, 8'h00);
  endtask

  task automatic sc_undervoltage();
    host_u.wr(A_CTRL, 8'h01);
    settle(4);
    cmp.supply_input <= 1'b0;
    // two sync flops, filter, enable and drive flop
    settle(6);
    chk({4'h0, drive.power_stage_en}, 8'h00);
    chk_rd(A_TOP_STAT, 8'h08);
    chk({4'h0, drive.discharge_en}, 8'h0f);
    cmp.supply_input <= 1'b1;
    wait_irq_low(700);
    chk_rd(A_INT_TOP, 8'h80);
    chk_rd(A_CTRL, 8'h00);
  endtask

  // pin gating latency is the same both ways; high warning level selected
  task automatic sc_pin_and_select();
    host_u.clear(A_INT_TOP, 8'h80);
    host_u.wr(A_CTRL, 8'h31);
    settle(6);
    chk({4'h0, drive.power_stage_en}, 8'h00);
    cmp.enable_pin_one <= 1'b1;
    settle(4);
    chk({4'h0, drive.power_stage_en}, 8'h00);
    settle(1);
    chk({4'h0, drive.power_stage_en}, 8'h01);
    cmp.enable_pin_one <= 1'b0;
    settle(4);
    chk({4'h0, drive.power_stage_en}, 8'h01);
    settle(1);
    chk({4'h0, drive.power_stage_en}, 8'h00);
    cmp.warn_lo <= 1'b1;
    settle(560);
    chk_rd(A_INT_TOP, 8'h00);
    cmp.warn_lo <= 1'b0;
    settle(1);
    cmp.warn_hi <= 1'b1;
    settle(560);
    chk_rd(A_INT_TOP, 8'h10);
    cmp.warn_hi <= 1'b0;
    settle(560);
    host_u.clear(A_INT_TOP, 8'h10);
  endtask

  // shutdown flag masked first, so the line stays high until unmasked
  task automatic sc_thermal();
    host_u.wr(A_MASK, 8'h08);
    host_u.wr(A_CTRL, 8'h01);
    settle(4);
    chk({4'h0, drive.power_stage_en}, 8'h01);
    cmp.tsd <= 1'b1;
    settle(560);
    chk({drive.power_stage_en, drive.discharge_en}, 8'h0f);
    chk_rd(A_INT_TOP, 8'h20);
    chk_rd(A_TOP_STAT, 8'h12);
    chk({7'h0, irq_out_n}, 8'h01);
    host_u.clear(A_INT_TOP, 8'h20);
    chk_rd(A_INT_TOP, 8'h20);
    cmp.tsd <= 1'b0;
    settle(560);
    chk({4'h0, drive.power_stage_en}, 8'h00);
    host_u.wr(A_MASK, 8'h00);
    settle(3);
    chk({7'h0, irq_out_n}, 8'h00);
    host_u.clear(A_INT_TOP, 8'h20);
    settle(4);
    chk({4'h0, drive.power_stage_en}, 8'h01);
    chk({7'h0, irq_out_n}, 8'h01);
  endtask

  initial
  begin
    cmp = '0;
    cmp.supply_input = 1'b1;
    settle(8);
    chk({7'h0, irq_out_n}, 8'h01);
    chip_reset_pin_n <= 1'b1;
    sc_power_up();
    sc_limit_and_short();
    sc_warning();
    sc_overload();
    sc_overvoltage();
    sc_undervoltage();
    sc_pin_and_select();
    sc_thermal();
    final_report();
  end
endmodule
`default_nettype wire
